// [shared/pms_pkg.sv]
// Purpose: Constants for the power mode supervisor
// Assumes: 32-bit APB, word-aligned registers
// Notes:   Offsets are byte addresses
package pms_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ    = 8'h08;
    localparam logic [7:0] ADDR_MASK   = 8'h0C;

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_DET_EN    = 0;
    localparam int CTRL_EDGE_FALL = 1;
    localparam int CTRL_EDGE_RISE = 2;
    localparam int CTRL_STOP_LP   = 3;
    localparam int CTRL_DEEP      = 4;
    localparam int CTRL_STANDBY   = 5;
    localparam int CTRL_W         = 6;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // ------------------------------------------------------------
    // Interrupt status bits
    // ------------------------------------------------------------
    localparam int IRQ_FALL = 0;
    localparam int IRQ_RISE = 1;
    localparam int IRQ_WAKE = 2;
    localparam int IRQ_W    = 3;

    // ------------------------------------------------------------
    // Regulator mode encoding
    // ------------------------------------------------------------
    localparam logic [1:0] REG_MAIN = 2'h0;
    localparam logic [1:0] REG_LOWP = 2'h1;
    localparam logic [1:0] REG_OFF  = 2'h2;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 100;
    localparam int RST_HOLD_NS   = 200;
    localparam int RST_HOLD_CYC  = (RST_HOLD_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_SLEEP,
        ST_STOP,
        ST_WAKE,
        ST_STANDBY
    } pms_state_e;

endpackage

// [design/pms_reset_hold.sv]
// Purpose: Holds device reset while supply low, then stretches release
// Assumes: i_supply_ok synchronous to the clock
// Notes:   Also restarts the stretch on a standby exit request
`timescale 1ns/100ps
module pms_reset_hold
    import pms_pkg::*;
#(
    parameter int HOLD_CYC = RST_HOLD_CYC
)(
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_supply_ok,
    input  wire logic i_restart,
    output logic      o_hold
);
    localparam int CW = $clog2(HOLD_CYC + 1);

    // A zero stretch would leave the counter without a terminal value
    if (HOLD_CYC < 1)
    begin : g_bad_hold
        $error("HOLD_CYC must be at least 1");
    end

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_hold;

    always_comb
    begin
        next_cnt  = cnt;
        next_hold = o_hold;
        if (!i_supply_ok || i_restart)
        begin
            next_cnt  = '0;
            next_hold = 1'b1;
        end
        else if (o_hold)
        begin
            if (cnt == CW'(HOLD_CYC - 1))
                next_hold = 1'b0;
            else
                next_cnt = cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            cnt    <= '0;
            o_hold <= 1'b1;
        end
        else
        begin
            cnt    <= next_cnt;
            o_hold <= next_hold;
        end
    end
endmodule

// [design/pms_top.sv]
// Purpose: Power mode supervisor: supply watch, regulator and clock gating
// Assumes: Supply comparators arrive as synchronous levels
// Notes:   APB slave with one wait state
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/100ps

// Functional notes
// - Device held in reset whenever main supply is below reset threshold.
// - Detector interrupts on falling, rising, or both threshold crossings.
// - Detector inactive until software enables it.
// - Regulator has main, low-power, off modes; main while running.
// - Stop mode may put regulator in low-power mode.
// - Standby powers regulator down; core state lost.
// - Regulator on after reset; off only in standby.
// - Sleep halts only processor clock; any interrupt wakes it.
// - Stop halts core clocks and all fast oscillators.
// - Software picks regulator mode for stop before entry.
// - Backup domain switches to battery when main supply absent.
module pms_top
    import pms_pkg::*;
#(
    parameter int HOLD_CYC = RST_HOLD_CYC
)(
    input  wire logic        I_CLOCK,
    input  wire logic        I_NRST,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    input  wire logic        i_supply_ok,
    input  wire logic        i_above_threshold,
    input  wire logic        i_wfi,
    input  wire logic        i_wake_event,
    output logic             o_sys_reset_n,
    output logic             o_cpu_clk_en,
    output logic             o_core_clk_en,
    output logic             o_rc_osc_en,
    output logic             o_pll_xtal_allow,
    output logic [1:0]       o_reg_mode,
    output logic             o_reg_en,
    output logic             o_backup_on_battery,
    output logic             o_wake_cpu,
    output logic             o_irq
);

    // ------------------------------------------------------------
    // Reset supervisor
    // ------------------------------------------------------------
    logic hold;
    logic standby_exit;
    logic held;

    pms_reset_hold #(
        .HOLD_CYC (HOLD_CYC)
    ) u_hold (
        .i_clk       (I_CLOCK),
        .i_nrst      (I_NRST),
        .i_supply_ok (i_supply_ok),
        .i_restart   (standby_exit),
        .o_hold      (hold)
    );

    // ------------------------------------------------------------
    // Registers and mode state
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] ctrl,      next_ctrl;
    logic [IRQ_W-1:0]  irq_stat,  next_irq_stat;
    logic [IRQ_W-1:0]  irq_mask,  next_irq_mask;
    logic              above_q,   next_above_q;
    logic              det_armed, next_det_armed;
    pms_state_e        state,     next_state;
    logic [31:0]       next_prdata;
    logic              next_pready;
    logic              next_pslverr;
    logic              wr_en;
    logic              rd_en;
    logic              mapped;
    logic              fall_evt;
    logic              rise_evt;
    logic              wake_evt;

    // Write lands on the completing edge, where the master sees pready
    assign wr_en  = i_psel && i_penable && i_pwrite && o_pready;
    assign rd_en  = i_psel && i_penable && !i_pwrite && !o_pready;
    assign mapped = (i_paddr == ADDR_CTRL) || (i_paddr == ADDR_STATUS)
                 || (i_paddr == ADDR_IRQ) || (i_paddr == ADDR_MASK);

    // Detector edges; baseline is re-caught when arming so enable is no edge
    assign fall_evt = det_armed && ctrl[CTRL_DET_EN] && ctrl[CTRL_EDGE_FALL]
                   && above_q && !i_above_threshold;
    assign rise_evt = det_armed && ctrl[CTRL_DET_EN] && ctrl[CTRL_EDGE_RISE]
                   && !above_q && i_above_threshold;
    assign wake_evt = (state == ST_STOP) && i_wake_event;

    always_comb
    begin
        next_ctrl      = ctrl;
        next_irq_mask  = irq_mask;
        next_irq_stat  = irq_stat;
        next_above_q   = i_above_threshold;
        next_det_armed = ctrl[CTRL_DET_EN];
        next_state     = state;
        next_prdata    = o_prdata;
        next_pready    = 1'b0;
        next_pslverr   = 1'b0;

        // Bus access; two-cycle access phase, one wait state
        if (i_psel && i_penable && !o_pready)
        begin
            next_pready  = 1'b1;
            next_pslverr = !mapped;
        end
        if (wr_en)
        begin
            unique case (i_paddr)
                ADDR_CTRL: next_ctrl = i_pwdata[CTRL_W-1:0];
                ADDR_MASK: next_irq_mask = i_pwdata[IRQ_W-1:0];
                ADDR_IRQ:  next_irq_stat = irq_stat & ~i_pwdata[IRQ_W-1:0];
                default:   next_ctrl = ctrl;
            endcase
        end
        if (rd_en)
        begin
            unique case (i_paddr)
                ADDR_CTRL:   next_prdata = {{(32-CTRL_W){1'b0}}, ctrl};
                ADDR_STATUS: next_prdata = {27'h0, i_above_threshold, 1'b0,
                                             o_reg_mode, o_cpu_clk_en};
                ADDR_IRQ:    next_prdata = {{(32-IRQ_W){1'b0}}, irq_stat};
                ADDR_MASK:   next_prdata = {{(32-IRQ_W){1'b0}}, irq_mask};
                default:     next_prdata = 32'h0000_0000;
            endcase
        end

        // Set wins over a same-cycle write-one clear
        if (fall_evt)
            next_irq_stat[IRQ_FALL] = 1'b1;
        if (rise_evt)
            next_irq_stat[IRQ_RISE] = 1'b1;
        if (wake_evt)
            next_irq_stat[IRQ_WAKE] = 1'b1;

        // Mode sequencing
        unique case (state)
            ST_RUN:
            begin
                if (i_wfi)
                begin
                    if (!ctrl[CTRL_DEEP])
                        next_state = ST_SLEEP;
                    else if (ctrl[CTRL_STANDBY])
                        next_state = ST_STANDBY;
                    else
                        next_state = ST_STOP;
                end
            end
            ST_SLEEP:
            begin
                if (i_wake_event || o_irq)
                    next_state = ST_RUN;
            end
            ST_STOP:
            begin
                if (i_wake_event)
                    next_state = ST_WAKE;
            end
            ST_WAKE:
            begin
                next_state = ST_RUN;
            end
            ST_STANDBY:
            begin
                // Only a wake pin leaves; state is gone so reset is replayed
                if (i_wake_event)
                    next_state = ST_RUN;
            end
        endcase
    end

    assign standby_exit = (state == ST_STANDBY) && i_wake_event;

    // Supply loss and standby exit reset at once; the stretch then follows
    assign held = hold || !i_supply_ok || standby_exit;

    always_ff @(posedge I_CLOCK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            ctrl      <= CTRL_RESET;
            irq_stat  <= '0;
            irq_mask  <= '0;
            above_q   <= 1'b0;
            det_armed <= 1'b0;
            state     <= ST_RUN;
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
        else if (held)
        begin
            // Whole block held while supply is low or standby is exited
            ctrl      <= CTRL_RESET;
            irq_stat  <= '0;
            irq_mask  <= '0;
            above_q   <= 1'b0;
            det_armed <= 1'b0;
            state     <= ST_RUN;
            o_prdata  <= 32'h0000_0000;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
        else
        begin
            ctrl      <= next_ctrl;
            irq_stat  <= next_irq_stat;
            irq_mask  <= next_irq_mask;
            above_q   <= next_above_q;
            det_armed <= next_det_armed;
            state     <= next_state;
            o_prdata  <= next_prdata;
            o_pready  <= next_pready;
            o_pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // Power and clock outputs
    // ------------------------------------------------------------
    logic [1:0] next_reg_mode;
    logic       next_reg_en;
    logic       next_cpu_clk_en;
    logic       next_core_clk_en;
    logic       next_rc_en;
    logic       next_pll_allow;
    logic       next_irq;

    always_comb
    begin
        next_reg_mode    = REG_MAIN;
        next_reg_en      = 1'b1;
        next_cpu_clk_en  = 1'b1;
        next_core_clk_en = 1'b1;
        next_rc_en       = 1'b1;
        next_pll_allow   = 1'b1;
        unique case (next_state)
            ST_RUN:
            begin
                next_reg_mode = REG_MAIN;
            end
            ST_SLEEP:
            begin
                next_cpu_clk_en = 1'b0;
            end
            ST_STOP:
            begin
                next_cpu_clk_en  = 1'b0;
                next_core_clk_en = 1'b0;
                next_rc_en       = 1'b0;
                next_pll_allow   = 1'b0;
                next_reg_mode    = ctrl[CTRL_STOP_LP] ? REG_LOWP
                                                      : REG_MAIN;
            end
            ST_WAKE:
            begin
                // RC first; PLL and crystal allowed again one cycle later, in run
                next_cpu_clk_en = 1'b0;
                next_pll_allow  = 1'b0;
            end
            ST_STANDBY:
            begin
                next_reg_mode    = REG_OFF;
                next_reg_en      = 1'b0;
                next_cpu_clk_en  = 1'b0;
                next_core_clk_en = 1'b0;
                next_rc_en       = 1'b0;
                next_pll_allow   = 1'b0;
            end
        endcase
        next_irq = |(next_irq_stat & irq_mask);
    end

    always_ff @(posedge I_CLOCK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            o_reg_mode          <= REG_MAIN;
            o_reg_en            <= 1'b1;
            o_cpu_clk_en        <= 1'b0;
            o_core_clk_en       <= 1'b0;
            o_rc_osc_en         <= 1'b1;
            o_pll_xtal_allow    <= 1'b0;
            o_sys_reset_n       <= 1'b0;
            o_backup_on_battery <= 1'b1;
            o_wake_cpu          <= 1'b0;
            o_irq               <= 1'b0;
        end
        else if (held)
        begin
            o_reg_mode          <= REG_MAIN;
            o_reg_en            <= 1'b1;
            o_cpu_clk_en        <= 1'b0;
            o_core_clk_en       <= 1'b0;
            o_rc_osc_en         <= 1'b1;
            o_pll_xtal_allow    <= 1'b0;
            o_sys_reset_n       <= 1'b0;
            o_backup_on_battery <= !i_supply_ok;
            o_wake_cpu          <= 1'b0;
            o_irq               <= 1'b0;
        end
        else
        begin
            o_reg_mode          <= next_reg_mode;
            o_reg_en            <= next_reg_en;
            o_cpu_clk_en        <= next_cpu_clk_en;
            o_core_clk_en       <= next_core_clk_en;
            o_rc_osc_en         <= next_rc_en;
            o_pll_xtal_allow    <= next_pll_allow;
            o_sys_reset_n       <= 1'b1;
            o_backup_on_battery <= !i_supply_ok;
            o_wake_cpu          <= (state == ST_WAKE)
                                || (state == ST_SLEEP && next_state == ST_RUN);
            o_irq               <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    reset_low_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        !i_supply_ok |=> !o_sys_reset_n)
        else $error("reset not held on low supply");

    det_off_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        !ctrl[CTRL_DET_EN] && !held |=> !($rose(irq_stat[IRQ_FALL])
                                       || $rose(irq_stat[IRQ_RISE])))
        else $error("detector fired while off");

    det_fall_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        fall_evt && !held |=> irq_stat[IRQ_FALL])
        else $error("falling crossing not flagged");

    run_main_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        state == ST_RUN && !hold && o_sys_reset_n |-> o_reg_mode == REG_MAIN)
        else $error("regulator not main in run");

    stop_lp_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        state == ST_STOP && !hold && ctrl[CTRL_STOP_LP] |-> o_reg_mode == REG_LOWP)
        else $error("stop regulator choice ignored");

    standby_off_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        o_reg_en == 1'b0 |-> $past(state) == ST_STANDBY || state == ST_STANDBY)
        else $error("regulator off outside standby");

    sleep_clk_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        state == ST_SLEEP && !hold |-> !o_cpu_clk_en && o_core_clk_en)
        else $error("sleep clock gating wrong");

    stop_osc_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        state == ST_STOP && !hold |-> !o_rc_osc_en && !o_pll_xtal_allow
                                   && !o_core_clk_en)
        else $error("oscillators running in stop");

    wake_rc_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        state == ST_STOP && i_wake_event && !held |=> o_rc_osc_en && !o_cpu_clk_en
                                                    ##1 o_cpu_clk_en)
        else $error("stop wake sequence wrong");

    standby_rst_a: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
        standby_exit |=> ##1 !o_sys_reset_n)
        else $error("standby exit without reset");

endmodule

// [tb/pms_core_model.sv]
// Purpose: Processor core stand-in: requests low-power entry, counts wakeups
// Assumes: Requests only after device reset is released
// Notes:   Wait-for-interrupt is a one-cycle pulse seen in RUN
`timescale 1ns/100ps
module pms_core_model
(
    input  wire logic       i_clk,
    input  wire logic       i_sys_reset_n,
    input  wire logic       i_wake_cpu,
    output logic            o_wfi,
    output logic [7:0]      o_wakes
);
    initial
    begin
        o_wfi = 1'b0;
        o_wakes = 8'h00;
    end

    // Every resume from sleep or stop is one pulse
    always @(posedge i_clk)
    begin
        if (i_wake_cpu === 1'b1)
            o_wakes <= o_wakes + 8'h01;
    end

    // A core held in reset cannot execute a wait instruction
    task automatic request();
        int n;
        n = 0;
        while (i_sys_reset_n !== 1'b1 && n < 50)
        begin
            @(posedge i_clk);
            n++;
        end
        @(posedge i_clk);
        o_wfi <= 1'b1;
        @(posedge i_clk);
        o_wfi <= 1'b0;
    endtask
endmodule

// [tb/power_mode_supervisor_tb.sv]
// Purpose: Self-checking bench for the power mode supervisor
// Assumes: One-wait-state APB slave, small reset stretch
// Notes:   Bus answers taken at the rising edge, other outputs at the falling
`timescale 1ns/100ps
module power_mode_supervisor_tb;
    import pms_pkg::*;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} pms_row_s;
    logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, sok = 1'b1, above = 1'b1, wfi, wake = 1'b0, e;
    logic        sys_rst_n, cpu_en, core_en, rc_en, pll, reg_en, batt, wake_cpu, irq;
    logic [1:0]  reg_mode;
    logic [7:0]  wakes;
    int          num_errors = 0, n_tests = 0, cyc = 0;
    pms_row_s    rows [7];

    always #5 clk = ~clk;

    pms_top #(.HOLD_CYC(2)) i_pms_top (.I_CLOCK(clk), .I_NRST(nrst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_supply_ok(sok),
        .i_above_threshold(above), .i_wfi(wfi), .i_wake_event(wake),
        .o_sys_reset_n(sys_rst_n), .o_cpu_clk_en(cpu_en), .o_core_clk_en(core_en),
        .o_rc_osc_en(rc_en), .o_pll_xtal_allow(pll), .o_reg_mode(reg_mode),
        .o_reg_en(reg_en), .o_backup_on_battery(batt), .o_wake_cpu(wake_cpu), .o_irq(irq));

    pms_core_model i_pms_core_model (.i_clk(clk), .i_sys_reset_n(sys_rst_n),
        .i_wake_cpu(wake_cpu), .o_wfi(wfi), .o_wakes(wakes));

    task automatic test_done();
        if (num_errors == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Request held until the edge that sees pready; only the bench timeout ends a wait
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic waitr(input logic v);
        int n;
        n = 0;
        while (sys_rst_n !== v && n < 40)
        begin
            @(negedge clk);
            n++;
        end
        chk(sys_rst_n, v);
    endtask

    // Peripheral event, one cycle long
    task automatic pulse_wake();
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        @(negedge clk);
    endtask

    task automatic set_above(input logic v);
        @(posedge clk);
        above <= v;
        repeat (4) @(negedge clk);
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            num_errors++;
            test_done();
        end
    end

    initial
    begin
        rows = '{'{1, ADDR_CTRL, 32'hFFFFFFC6, 0, 0}, '{0, ADDR_CTRL, 0, 32'h06, 0},
                 '{1, ADDR_MASK, 32'hFFFFFFFF, 0, 0}, '{0, ADDR_MASK, 0, 32'h07, 0},
                 '{1, ADDR_STATUS, 32'hFFFFFFFF, 0, 0}, '{0, ADDR_STATUS, 0, 32'h11, 0},
                 '{0, 8'h10, 0, 32'h0, 1}};
        repeat (3) @(posedge clk);
        chk({sys_rst_n, reg_en, reg_mode}, {1'b0, 1'b1, REG_MAIN});
        nrst <= 1'b1;
        waitr(1'b1);
        chk({cpu_en, core_en, reg_en, reg_mode}, {3'b111, REG_MAIN});
        // ----------------------------------------------------------
        // Register table
        // ----------------------------------------------------------
        foreach (rows[i])
        begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            if (!rows[i].wr)
                chk(q, rows[i].x);
            chk(e, rows[i].e);
        end
        // ----------------------------------------------------------
        // Supply detector
        // ----------------------------------------------------------
        apb(1, ADDR_CTRL, 32'h0);
        set_above(1'b0);
        set_above(1'b1);
        apb(0, ADDR_IRQ, 0);
        chk(q, 32'h0);
        apb(1, ADDR_MASK, 32'h7);
        apb(1, ADDR_CTRL, 32'h7);
        set_above(1'b0);
        chk(irq, 1'b1);
        apb(0, ADDR_IRQ, 0);
        chk(q, 32'h1);
        apb(1, ADDR_IRQ, 32'h1);
        set_above(1'b1);
        apb(0, ADDR_IRQ, 0);
        chk(q, 32'h2);
        apb(1, ADDR_MASK, 32'h0);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
        apb(1, ADDR_IRQ, 32'h7);
        apb(1, ADDR_CTRL, 32'h0);
        // ----------------------------------------------------------
        // Sleep, stop and standby
        // ----------------------------------------------------------
        i_pms_core_model.request();
        @(negedge clk);
        chk({cpu_en, core_en, reg_mode}, {2'b01, REG_MAIN});
        pulse_wake();
        chk({cpu_en, wake_cpu}, 2'b11);
        @(negedge clk);
        chk({wake_cpu, wakes}, {1'b0, 8'h01});
        for (int lp = 0; lp < 2; lp++)
        begin
            apb(1, ADDR_CTRL, 32'h10 | (lp << 3));
            i_pms_core_model.request();
            @(negedge clk);
            chk({cpu_en, core_en, rc_en, pll, reg_en}, 5'b00001);
            chk(reg_mode, lp ? REG_LOWP : REG_MAIN);
            pulse_wake();
            chk({rc_en, cpu_en, pll}, 3'b100);
            @(negedge clk);
            chk({cpu_en, pll, wake_cpu, reg_mode}, {3'b111, REG_MAIN});
        end
        apb(0, ADDR_IRQ, 0);
        chk(q, 32'h4);
        chk(wakes, 8'h03);
        apb(1, ADDR_MASK, 32'h4);
        repeat (2) @(negedge clk);
        chk(irq, 1'b1);
        apb(1, ADDR_IRQ, 32'h4);
        repeat (2) @(negedge clk);
        chk(irq, 1'b0);
        apb(1, ADDR_CTRL, 32'h30);
        i_pms_core_model.request();
        @(negedge clk);
        chk({reg_en, reg_mode}, {1'b0, REG_OFF});
        pulse_wake();
        waitr(1'b0);
        waitr(1'b1);
        chk({reg_en, reg_mode}, {1'b1, REG_MAIN});
        apb(0, ADDR_CTRL, 0);
        chk(q, 32'h0);
        // ----------------------------------------------------------
        // Supply loss in mid-run
        // ----------------------------------------------------------
        @(posedge clk);
        sok <= 1'b0;
        repeat (5) @(negedge clk);
        chk({sys_rst_n, batt}, 2'b01);
        @(posedge clk);
        sok <= 1'b1;
        waitr(1'b1);
        chk(batt, 1'b0);
        test_done();
    end
endmodule
